// [mfd_pkg.sv]
// Purpose: shared constants for the motor feedback decoder
// Assumes: 20 MHz clock, synchronous active-high reset
// Notes: command source, control mode and alignment state encodings
`default_nettype none
package mfd_pkg;
    localparam int MFD_POS_W = 32;
    localparam int MFD_VEL_W = 16;
    localparam int MFD_INTERP_W = 4;
    localparam logic [3:0] MFD_INTERP_MAX_LOG2 = 4'h9;
    localparam logic [31:0] MFD_CLK_HZ = 32'd20000000;
    localparam int MFD_VEL_WINDOW_US = 1000;
    localparam int MFD_VEL_WINDOW_CYC = (MFD_VEL_WINDOW_US * 20);
    localparam int MFD_ALIGN_TIME_US = 100000;
    localparam int MFD_ALIGN_CYC = (MFD_ALIGN_TIME_US * 20);
    localparam logic [MFD_POS_W-1:0] MFD_POS_RESET = 32'h00000000;
    typedef enum logic [1:0] {
        MFD_SRC_PROGRAM = 2'b00,
        MFD_SRC_ANALOG = 2'b01,
        MFD_SRC_NETWORK = 2'b10,
        MFD_SRC_FOLLOW = 2'b11
    } mfd_src_t;
    typedef enum logic [1:0] {
        MFD_MODE_CURRENT = 2'b00,
        MFD_MODE_VELOCITY = 2'b01,
        MFD_MODE_POSITION = 2'b10
    } mfd_mode_t;
    typedef enum logic [1:0] {
        MFD_AL_IDLE = 2'b00,
        MFD_AL_DRIVE = 2'b01,
        MFD_AL_DONE = 2'b10
    } mfd_align_t;
endpackage
`default_nettype wire

// [mfd_decoder.sv]
// Purpose: quadrature, sin/cos count, hall and command-source front end
// Assumes: all inputs synchronous to clock; single-ended levels after receivers
// Notes: outputs all registered
// Behaviour
// - feedback valid when both encoder channels are present and driven, or when the absolute source is selected.
// - direction from which channel leads; speed from pulse arrival rate.
// - optional index zeroes count for homing; works with index absent.
// - signed count kept relative to home, reported as absolute location.
// - interpolation factor is a power of two from 1 to 512.
// - counts per sin/cos cycle equal interpolation factor times four.
// - polarity setting inverts internally used velocity feedback sign.
// - error is command minus feedback; output drives error toward zero.
// - hall transition rate becomes velocity with speed and direction.
// - auxiliary encoder routes to command following or secondary feedback.
// - absolute encoder position is valid at power-on without homing.
// - alignment applies small current, watches movement, sets commutation start.
// - exactly one command source active at a time.
// - encoder following allowed only in position mode, else rejected.
`default_nettype none
module mfd_decoder
    import mfd_pkg::*;
#(
    parameter int VEL_WINDOW_CYC = MFD_VEL_WINDOW_CYC,
    parameter int ALIGN_CYC = MFD_ALIGN_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_a_n,
    input wire logic enc_b_n,
    input wire logic enc_index,
    input wire logic index_enable,
    input wire logic home_request,
    input wire logic [2:0] hall,
    input wire logic aux_a,
    input wire logic aux_b,
    input wire logic aux_as_follow,
    input wire logic [3:0] interp_log2,
    input wire logic sincos_step,
    input wire logic sincos_dir,
    input wire logic sincos_select,
    input wire logic absolute_select,
    input wire logic [MFD_POS_W-1:0] absolute_pos,
    input wire logic polarity_invert,
    input wire logic [1:0] mode,
    input wire logic [1:0] source_request,
    input wire logic [MFD_POS_W-1:0] command_value,
    input wire logic align_start,
    output logic [MFD_POS_W-1:0] position,
    output logic [MFD_VEL_W-1:0] velocity,
    output logic [MFD_VEL_W-1:0] hall_velocity,
    output logic direction,
    output logic feedback_valid,
    output logic homed,
    output logic quad_error,
    output logic [MFD_POS_W-1:0] aux_command,
    output logic [MFD_POS_W-1:0] aux_position,
    output logic [MFD_POS_W-1:0] loop_error,
    output logic [1:0] active_source,
    output logic source_rejected,
    output logic align_current_on,
    output logic [MFD_POS_W-1:0] commutation_offset,
    output logic align_done
);
    logic a_q, b_q, ix_q, ax_a_q, ax_b_q;
    logic [2:0] hall_q;
    logic [MFD_POS_W-1:0] pos_q, aux_q, axp_q, err_q, off_q;
    logic [MFD_VEL_W-1:0] vel_q, hvel_q, pcnt_q, hcnt_q;
    logic [31:0] win_q, al_cnt_q;
    logic dir_q, valid_q, homed_q, qerr_q, hdir_q, rej_q, hm_q, on_q, done_q;
    logic [MFD_POS_W-1:0] pout_q;
    logic [1:0] src_q;
    mfd_align_t al_q;

    // complementary pairs prove the channel is actually driven
    wire present = (enc_a ^ enc_a_n) & (enc_b ^ enc_b_n);
    wire ch_a = a_q ^ enc_a;
    wire ch_b = b_q ^ enc_b;
    wire both = ch_a & ch_b;
    wire one_step = (ch_a ^ ch_b) & present;
    // leading channel: a changed and now differs from b means forward
    wire fwd = ch_a ? (enc_a != b_q) : (enc_b == a_q);
    wire index_rise = enc_index & ~ix_q & index_enable;
    wire [MFD_POS_W-1:0] lsb_weight = {{(MFD_POS_W-1){1'b0}}, 1'b1};
    // clamp keeps the factor inside the 1..512 power-of-two range
    wire [3:0] il2 = (interp_log2 > MFD_INTERP_MAX_LOG2) ? MFD_INTERP_MAX_LOG2 :
        interp_log2;
    // one analog cycle yields factor*4 counts; a step is a quarter cycle worth factor counts
    wire [MFD_POS_W-1:0] sc_weight = lsb_weight << il2;
    wire step_fwd = sincos_select ? sincos_dir : fwd;
    wire step_any = sincos_select ? sincos_step : one_step;
    wire [MFD_POS_W-1:0] step_amt = sincos_select ? sc_weight : lsb_weight;
    wire [MFD_POS_W-1:0] pos_step = step_fwd ? pos_q + step_amt : pos_q - step_amt;
    wire [MFD_POS_W-1:0] pos_d = (index_rise || home_request) ? MFD_POS_RESET :
        step_any ? pos_step : pos_q;
    wire win_end = (win_q == 32'(VEL_WINDOW_CYC - 1));
    wire [MFD_VEL_W-1:0] pcnt_step = pcnt_q + {{(MFD_VEL_W-1){1'b0}}, step_any};
    // the step on the window's last edge counts too, else speed reads one low
    wire vel_dir = step_any ? step_fwd : dir_q;
    wire [MFD_VEL_W-1:0] vel_raw = vel_dir ? pcnt_step : -pcnt_step;
    wire [MFD_VEL_W-1:0] vel_fb = polarity_invert ? -vel_raw : vel_raw;
    wire hall_edge = (hall != hall_q);
    // hall forward sequence: a leads b leads c
    wire hall_fwd = (hall_q == 3'h1 && hall == 3'h3) || (hall_q == 3'h3 && hall == 3'h2) ||
        (hall_q == 3'h2 && hall == 3'h6) || (hall_q == 3'h6 && hall == 3'h4) ||
        (hall_q == 3'h4 && hall == 3'h5) || (hall_q == 3'h5 && hall == 3'h1);
    wire [MFD_VEL_W-1:0] hcnt_step = hcnt_q + {{(MFD_VEL_W-1){1'b0}}, hall_edge};
    wire hvel_dir = hall_edge ? hall_fwd : hdir_q;
    wire [MFD_VEL_W-1:0] hvel_raw = hvel_dir ? hcnt_step : -hcnt_step;
    wire [MFD_VEL_W-1:0] hvel_fb = polarity_invert ? -hvel_raw : hvel_raw;
    wire ax_ch = (ax_a_q ^ aux_a) ^ (ax_b_q ^ aux_b);
    wire ax_fwd = (ax_a_q ^ aux_a) ? (aux_a != ax_b_q) : (aux_b == ax_a_q);
    wire [MFD_POS_W-1:0] ax_base = aux_as_follow ? aux_q : axp_q;
    wire [MFD_POS_W-1:0] ax_next = ax_fwd ? ax_base + lsb_weight : ax_base - lsb_weight;
    wire follow_bad = (source_request == MFD_SRC_FOLLOW) &&
        ((mode != MFD_MODE_POSITION) || !aux_as_follow);
    wire [MFD_POS_W-1:0] fb_pos = pout_q;
    wire [MFD_POS_W-1:0] cmd_sel = (src_q == MFD_SRC_FOLLOW) ? aux_q : command_value;
    wire [MFD_POS_W-1:0] fb_sel = aux_as_follow ? fb_pos : axp_q;
    wire [MFD_POS_W-1:0] err_d = cmd_sel - fb_sel;
    wire al_timeout = (al_cnt_q == 32'(ALIGN_CYC - 1));

    always_ff @(posedge clock) begin
        a_q <= enc_a;
        b_q <= enc_b;
        ix_q <= enc_index;
        hall_q <= hall;
        ax_a_q <= aux_a;
        ax_b_q <= aux_b;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pos_q <= MFD_POS_RESET;
            pout_q <= MFD_POS_RESET;
            homed_q <= 1'b0;
            hm_q <= 1'b0;
            dir_q <= 1'b0;
            qerr_q <= 1'b0;
        end else begin
            // absolute source bypasses the count with the same latency
            pout_q <= absolute_select ? absolute_pos : pos_d;
            hm_q <= homed_q | index_rise | home_request | absolute_select;
            if (index_rise || home_request) begin
                pos_q <= MFD_POS_RESET;
                homed_q <= 1'b1;
            end else if (step_any) begin
                pos_q <= pos_step;
                dir_q <= step_fwd;
            end
            if (both && present) qerr_q <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            win_q <= 32'h00000000;
            pcnt_q <= '0;
            hcnt_q <= '0;
            vel_q <= '0;
            hvel_q <= '0;
            hdir_q <= 1'b0;
        end else begin
            win_q <= win_end ? 32'h00000000 : win_q + 32'h00000001;
            pcnt_q <= win_end ? '0 : pcnt_step;
            hcnt_q <= win_end ? '0 : hcnt_step;
            if (win_end) vel_q <= vel_fb;
            if (win_end) hvel_q <= hvel_fb;
            if (hall_edge) hdir_q <= hall_fwd;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            valid_q <= 1'b0;
            aux_q <= '0;
            axp_q <= '0;
            err_q <= '0;
            src_q <= MFD_SRC_PROGRAM;
            rej_q <= 1'b0;
        end else begin
            // absolute feedback needs no homing to be trusted
            valid_q <= absolute_select | present;
            if (ax_ch && aux_as_follow) aux_q <= ax_next;
            if (ax_ch && !aux_as_follow) axp_q <= ax_next;
            err_q <= err_d;
            // a rejected request keeps the previous single source
            if (!follow_bad) src_q <= source_request;
            rej_q <= follow_bad;
        end
    end

    // limitation: offset is simply the count after settling, no sector math
    always_ff @(posedge clock) begin
        if (rst) begin
            al_q <= MFD_AL_IDLE;
            al_cnt_q <= 32'h00000000;
            off_q <= '0;
            on_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            case (al_q)
                MFD_AL_IDLE: begin
                    al_cnt_q <= 32'h00000000;
                    if (align_start) begin
                        al_q <= MFD_AL_DRIVE;
                        on_q <= 1'b1;
                    end
                end
                MFD_AL_DRIVE: begin
                    al_cnt_q <= al_cnt_q + 32'h00000001;
                    if (al_timeout) begin
                        off_q <= pos_q;
                        al_q <= MFD_AL_DONE;
                        on_q <= 1'b0;
                        done_q <= 1'b1;
                    end
                end
                MFD_AL_DONE: begin
                    // a rerun must start its timer from zero
                    al_cnt_q <= 32'h00000000;
                    if (align_start) begin
                        al_q <= MFD_AL_DRIVE;
                        on_q <= 1'b1;
                        done_q <= 1'b0;
                    end
                end
                default: begin
                    al_q <= MFD_AL_IDLE;
                    on_q <= 1'b0;
                    done_q <= 1'b0;
                end
            endcase
        end
    end

    assign position = pout_q;
    assign velocity = vel_q;
    assign hall_velocity = hvel_q;
    assign direction = dir_q;
    assign feedback_valid = valid_q;
    assign homed = hm_q;
    assign quad_error = qerr_q;
    assign aux_command = aux_q;
    assign aux_position = axp_q;
    assign loop_error = err_q;
    assign active_source = src_q;
    assign source_rejected = rej_q;
    assign align_current_on = on_q;
    assign commutation_offset = off_q;
    assign align_done = done_q;
endmodule
`default_nettype wire

// [mfd_decoder_props.sv]
// Purpose: port checks for mfd_decoder
// Assumes: counts shortened by parameters
// Notes: override inputs are kept out of the counting checks
`default_nettype none
module mfd_decoder_props #(parameter int VEL_WINDOW_CYC = 16, parameter int ALIGN_CYC = 8) (
    input wire logic clock, rst, enc_a, enc_b, enc_a_n, enc_b_n, enc_index, home_request,
    input wire logic sincos_step, sincos_dir, sincos_select, absolute_select, aux_as_follow,
    input wire logic feedback_valid, homed, quad_error, direction, source_rejected,
    input wire logic [3:0] interp_log2,
    input wire logic [1:0] mode, source_request, active_source,
    input wire logic [31:0] command_value, position, loop_error
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    // home, index and absolute override counting
    wire logic ok = enc_a_n != enc_a && enc_b_n != enc_b && !home_request && !enc_index
        && !absolute_select;
    a_fwd_step: assert property (
        ok && feedback_valid && !sincos_select && $rose(enc_a) && !enc_b && $stable(enc_b)
        |=> position == $past(position) + 32'h1 && direction) else $error("forward step lost");
    a_both_error: assert property (
        ok && !sincos_select && $changed(enc_a) && $changed(enc_b)
        |=> quad_error && $stable(position)) else $error("double change not flagged");
    a_error_sticky: assert property (
        quad_error |=> quad_error) else $error("error flag dropped");
    a_sincos_weight: assert property (
        ok && feedback_valid && sincos_select && sincos_step && sincos_dir && interp_log2 <= 4'h9
        |=> position == $past(position) + (32'h1 << $past(interp_log2))) else $error("bad weight");
    a_home_zero: assert property (
        home_request && !absolute_select |=> position == 32'h0 && homed) else $error("home lost");
    a_loop_diff: assert property (
        aux_as_follow && active_source != 2'h3 && $stable(position) && $stable(command_value)
        |=> loop_error == $past(command_value) - $past(position)) else $error("bad loop error");
    a_follow_reject: assert property (
        source_request == 2'h3 && (mode != 2'h2 || !aux_as_follow)
        |=> source_rejected && $stable(active_source)) else $error("follow not refused");
    a_source_take: assert property (
        source_request != 2'h3 |=> active_source == $past(source_request) && !source_rejected)
        else $error("source not taken");
endmodule
`default_nettype wire

// [mfd_enc_model.sv]
// Purpose: motor encoder and hall sensor model
// Assumes: commands sampled on the rising edge
// Notes: skip moves both channels at once, a fault only on request
`default_nettype none
module mfd_enc_model (
    input wire logic clock, fwd, rev, skip, present, hstep,
    output logic a, b, a_n, b_n,
    output logic [2:0] hall
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] st = 2'h0;
    logic [2:0] hi = 3'h0;
    logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    always @(posedge clock) begin
        st <= #2 st + (fwd ? 2'h1 : rev ? 2'h3 : skip ? 2'h2 : 2'h0);
        if (hstep)
            hi <= #2 3'(fwd ? (hi + 4'h1) % 4'h6 : (hi + 4'h5) % 4'h6);
    end
    assign a = ^st; // a leads b going forward
    assign b = st[1];
    assign a_n = present ? ~a : a; // an open pair never reads complementary
    assign b_n = present ? ~b : b;
    assign hall = seq[hi];
endmodule
`default_nettype wire

// [mfd_decoder_tb.sv]
// Purpose: self-checking bench for mfd_decoder
// Assumes: window of 16 and alignment of 8 cycles
// Notes: main and auxiliary encoders come from the model
`default_nettype none
module mfd_decoder_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0, rst = 1'b1, fwd = 1'b0, rev = 1'b0, skip = 1'b0, hst = 1'b0, pres = 1'b1;
    logic afwd = 1'b0, idx = 1'b0, idx_en = 1'b0, home = 1'b0, aux_f = 1'b1, sc_step = 1'b0;
    logic sc_sel = 1'b0, abs_sel = 1'b0, pol = 1'b0, al_go = 1'b0, dl, rej;
    logic sc_dir = 1'b1, arev = 1'b0;
    logic [3:0] lg = 4'h0;
    logic [1:0] md = 2'h2, req = 2'h0, act = 2'h0, active_source;
    logic [31:0] cmd = 32'h0, abs_v = 32'h0, ex = 32'h0;
    logic a, b, a_n, b_n, xa, xb, direction, feedback_valid, homed, quad_error;
    logic source_rejected, align_current_on, align_done;
    logic [2:0] hall;
    logic [31:0] position, aux_command, aux_position, loop_error, commutation_offset;
    logic [15:0] velocity, hall_velocity;
    int mismatches = 0, checks_done = 0, cyc_n = 0;
    always #25 clock = ~clock;
    mfd_enc_model M (.clock, .fwd, .rev, .skip, .present(pres), .hstep(hst), .a, .b, .a_n, .b_n,
        .hall);
    mfd_enc_model X (.clock, .fwd(afwd), .rev(arev), .skip(1'b0), .present(1'b1), .hstep(1'b0),
        .a(xa), .b(xb), .a_n(), .b_n(), .hall());
    mfd_decoder #(.VEL_WINDOW_CYC(16), .ALIGN_CYC(8)) DUT (.clock, .rst, .enc_a(a), .enc_b(b),
        .enc_a_n(a_n), .enc_b_n(b_n), .enc_index(idx), .index_enable(idx_en), .home_request(home),
        .hall, .aux_a(xa), .aux_b(xb), .aux_as_follow(aux_f), .interp_log2(lg),
        .sincos_step(sc_step), .sincos_dir(sc_dir), .sincos_select(sc_sel),
        .absolute_select(abs_sel), .absolute_pos(abs_v), .polarity_invert(pol), .mode(md),
        .source_request(req), .command_value(cmd), .align_start(al_go), .position, .velocity,
        .hall_velocity, .direction, .feedback_valid, .homed, .quad_error, .aux_command,
        .aux_position, .loop_error, .active_source, .source_rejected, .align_current_on,
        .commutation_offset, .align_done);
    function automatic logic [15:0] vel_exp(logic fw, logic inv);
        return (fw ^ inv) ? 16'h0008 : 16'hfff8; // steps every other cycle in a 16-cycle window
    endfunction
    function automatic logic [31:0] sc_w(logic [3:0] l);
        return 32'h1 << ((l > 4'h9) ? 4'h9 : l);
    endfunction
    task automatic tick(int n);
        repeat (n) @(posedge clock);
        #5;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic final_report();
        if (mismatches == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc_n++;
        if (cyc_n == 2000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        void'($urandom(56));
        tick(20);
        rst = 1'b0;
        tick(2);
        repeat (40) begin
            {fwd, rev} = 2'($urandom_range(1, 2));
            dl = fwd;
            ex = fwd ? ex + 32'h1 : ex - 32'h1;
            tick(1);
        end
        {fwd, rev} = 2'h0;
        tick(3);
        chk("position", ex, position);
        chk("direction", {31'h0, dl}, {31'h0, direction});
        // pair opened with the step, so the step must not count
        {fwd, pres} = 2'h2;
        tick(1);
        fwd = 1'b0;
        tick(3);
        chk("valid", 32'h0, {31'h0, feedback_valid});
        chk("position", ex, position);
        {pres, idx_en, idx, ex} = {3'h7, 32'h0};
        tick(3);
        chk("index", ex, position);
        chk("homed", 32'h1, {31'h0, homed});
        {idx_en, idx} = 2'h0;
        for (int k = 0; k < 4; k++) begin
            pol = k[1];
            repeat (24) begin
                {fwd, rev, hst} = {k[0], !k[0], 1'b1};
                tick(1);
                {fwd, rev, hst} = 3'h0;
                tick(1);
            end
            chk("velocity", vel_exp(k[0], k[1]), velocity);
            chk("hall velocity", vel_exp(k[0], k[1]), hall_velocity);
        end
        {pol, sc_sel} = 2'h1;
        for (int k = 0; k < 11; k++) begin
            lg = (k == 10) ? 4'hf : k[3:0];
            sc_dir = k != 4;
            ex = sc_dir ? ex + sc_w(lg) : ex - sc_w(lg);
            sc_step = 1'b1;
            tick(1);
            sc_step = 1'b0;
            tick(1);
        end
        chk("sincos", ex, position);
        {sc_sel, home, ex} = {2'h1, 32'h0};
        tick(1);
        {home, skip} = 2'h1;
        tick(1);
        skip = 1'b0;
        tick(3);
        chk("quad error", 32'h1, {31'h0, quad_error});
        chk("position", ex, position);
        for (int k = 0; k < 16; k++) begin
            {aux_f, md} = (k > 11) ? 3'h2 : {1'b1, k[3:2]};
            req = k[1:0];
            rej = req == 2'h3 && (md != 2'h2 || !aux_f);
            act = rej ? act : req;
            tick(2);
            chk("source", {30'h0, act}, {30'h0, active_source});
            chk("rejected", {31'h0, rej}, {31'h0, source_rejected});
        end
        req = 2'h0;
        for (int k = 0; k < 2; k++) begin
            aux_f = k[0];
            repeat (5) begin
                afwd = 1'b1;
                tick(1);
                afwd = 1'b0;
                tick(1);
            end
            arev = 1'b1;
            tick(1);
            arev = 1'b0;
            tick(2);
            if (k[0])
                chk("aux command", 32'h4, aux_command);
            else
                chk("aux position", 32'h4, aux_position);
        end
        repeat (4) begin
            cmd = $urandom;
            tick(3);
            chk("loop error", cmd - ex, loop_error);
        end
        {abs_sel, pres, abs_v} = {2'h2, $urandom};
        tick(3);
        chk("absolute", abs_v, position);
        chk("valid", 32'h1, {31'h0, feedback_valid});
        {abs_sel, pres, home} = 3'h3;
        tick(1);
        {home, al_go} = 2'h1;
        tick(1);
        {al_go, fwd} = 2'h1;
        chk("current on", 32'h1, {31'h0, align_current_on});
        tick(3);
        fwd = 1'b0;
        for (int i = 0; i < 20 && align_done !== 1'b1; i++)
            tick(1);
        chk("align done", 32'h1, {31'h0, align_done});
        chk("offset", 32'h3, commutation_offset);
        final_report();
    end
endmodule
bind mfd_decoder mfd_decoder_props #(.VEL_WINDOW_CYC(VEL_WINDOW_CYC), .ALIGN_CYC(ALIGN_CYC)) P (
    .clock, .rst, .enc_a, .enc_b, .enc_a_n, .enc_b_n, .enc_index, .home_request, .sincos_step,
    .sincos_dir, .sincos_select, .absolute_select, .aux_as_follow, .feedback_valid, .homed,
    .quad_error, .direction, .source_rejected, .interp_log2, .mode, .source_request,
    .active_source, .command_value, .position, .loop_error);
`default_nettype wire
